// [ppdr_pkg.sv]
// palette, power-save and display-mode register bank: shared constants and types
// assumes one 10 MHz clock shared by both ends and a synchronous active-high reset
package ppdr_pkg;

	// ***********************************
	// device register offsets
	// ***********************************
	localparam logic [8:0] PPDR_OFF_TABLE_SEL = 9'h1E0;
	localparam logic [8:0] PPDR_OFF_INDEX_PTR = 9'h1E2;
	localparam logic [8:0] PPDR_OFF_DATA_PORT = 9'h1E4;
	localparam logic [8:0] PPDR_OFF_PS_CONFIG = 9'h1F0;
	localparam logic [8:0] PPDR_OFF_PS_STATE = 9'h1F1;
	localparam logic [8:0] PPDR_OFF_WATCHDOG = 9'h1F4;
	localparam logic [8:0] PPDR_OFF_DISP_MODE = 9'h1FC;

	// ***********************************
	// field positions and reset values
	// ***********************************
	localparam int PPDR_PS_ENABLE_BIT = 0;
	localparam int PPDR_PS_RSVD_BIT = 4;
	localparam int PPDR_ST_LCD_BIT = 1;
	localparam int PPDR_ST_MEM_BIT = 0;
	localparam int PPDR_DM_ROT_BIT = 6;
	localparam int PPDR_DATA_LSB = 4;
	localparam int PPDR_WD_W = 6;
	localparam logic [7:0] PPDR_RESET_BYTE = 8'h00;

	// ***********************************
	// watchdog bound: (8n + 7) bus clocks + 13 memory clocks
	// ***********************************
	localparam int PPDR_WD_MULT = 8;
	localparam int PPDR_WD_ADD = 7;
	localparam logic [3:0] PPDR_WD_MCLKS = 4'hD;
	localparam int PPDR_WD_CNT_W = 11;

	// ***********************************
	// host side avalon word addresses
	// ***********************************
	localparam logic [2:0] PPDR_AV_ADDR = 3'h0;
	localparam logic [2:0] PPDR_AV_WDATA = 3'h1;
	localparam logic [2:0] PPDR_AV_CTRL = 3'h2;
	localparam logic [2:0] PPDR_AV_STATUS = 3'h3;

	// ***********************************
	// enumerations
	// ***********************************
	typedef enum logic [1:0] {
		PPDR_TS_BOTH = 2'b00,
		PPDR_TS_LCD = 2'b01,
		PPDR_TS_CRT = 2'b10,
		PPDR_TS_RSVD = 2'b11
	} ppdr_tsel_t;

	typedef enum logic [1:0] {
		PPDR_PH_RED = 2'b00,
		PPDR_PH_GREEN = 2'b01,
		PPDR_PH_BLUE = 2'b10
	} ppdr_phase_t;

	typedef enum logic [1:0] {
		PPDR_WD_IDLE = 2'b00,
		PPDR_WD_BUS = 2'b01,
		PPDR_WD_MCLK = 2'b10,
		PPDR_WD_EXPIRE = 2'b11
	} ppdr_wd_t;

endpackage

// [ppdr_if.sv]
// register access link between the host controller and the register bank
// assumes both ends run on the same clock; req is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface ppdr_if;
	logic req;
	logic we;
	logic [8:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;

	modport device (input req, input we, input addr, input wdata, output rdata, output ack);
	modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// [ppdr_device.sv]
// register bank end: palette tables, power-save, watchdog, display mode
// assumes the host keeps its own obligations and sends one request at a time
//
// How it works
// - table select steers palette reads and writes
// - two palette tables, lcd and crt, each 256 by three 4-bit components
// - pointer write loads index, phase red
// - data access steps red green blue next
// - table changes only on blue write
// - colour component sits in bits 7-4
// - host avoids palette with stopped clock
// - config bit 0 enables power save
// - host writes reserved bit 4 as 0
// - status bit 1 shows panel down
// - status bit 0 shows memory down
// - clocks stop only after status reads 1
// - non-zero watchdog value enables it
// - cycle ends within 8n+7 plus 13
// - strap doubles the bus clock period
// - watchdog bounds cpu memory cycles only
// - mode bit 6 rotates image 90 degrees
// - three-bit output select decode
// - bit 0 edges start lcd power sequence
// - host sets tv config for flicker
// - flicker filter averages adjacent lines
`timescale 1ns/10ps
`default_nettype none
module ppdr_device
	import ppdr_pkg::*;
#(
	parameter int DEPTH = 256,
	parameter int COMP_W = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register link
	ppdr_if.device link,
	// power state inputs
	input wire logic panel_powered_down,
	input wire logic memctl_powered_down,
	// watchdog inputs
	input wire logic cpu_mem_cycle,
	input wire logic mclk_tick,
	input wire logic bus_clock_divide_strap,
	// palette lookup for the pixel pipelines
	input wire logic [7:0] lcd_index,
	input wire logic [7:0] crt_index,
	output logic [3*COMP_W-1:0] lcd_rgb,
	output logic [3*COMP_W-1:0] crt_rgb,
	// tv line pair for the flicker filter
	input wire logic [3*COMP_W-1:0] tv_line_cur,
	input wire logic [3*COMP_W-1:0] tv_line_prev,
	output logic [3*COMP_W-1:0] tv_pix,
	// control outputs
	output logic power_save_enable,
	output logic image_rotation_90,
	output logic lcd_enable,
	output logic crt_enable,
	output logic tv_enable,
	output logic flicker_enable,
	output logic simultaneous_display,
	output logic lcd_power_on_start,
	output logic lcd_power_off_start,
	output logic mem_cycle_terminate
);

	// ***********************************
	// storage
	// ***********************************
	logic [3:0] lcd_tab [0:2][0:DEPTH-1];
	logic [3:0] crt_tab [0:2][0:DEPTH-1];
	ppdr_tsel_t tsel_q;
	logic [7:0] ptr_q;
	ppdr_phase_t phase_q;
	logic [COMP_W-1:0] stage_red_q, stage_green_q;
	logic ps_en_q, ps_rsvd_q;
	logic [PPDR_WD_W-1:0] wd_n_q;
	logic rot_q;
	logic [2:0] dsel_q;
	logic ack_q;
	logic [7:0] rdata_q;
	logic strap_q;
	ppdr_wd_t wd_q;
	logic [PPDR_WD_CNT_W-1:0] wd_cnt_q;
	logic [3:0] wd_mclk_q;

	// ***********************************
	// address decode
	// ***********************************
	wire wr = link.req & link.we;
	wire hit_tsel = link.addr == PPDR_OFF_TABLE_SEL;
	wire hit_ptr = link.addr == PPDR_OFF_INDEX_PTR;
	wire hit_data = link.addr == PPDR_OFF_DATA_PORT;
	wire hit_cfg = link.addr == PPDR_OFF_PS_CONFIG;
	wire hit_st = link.addr == PPDR_OFF_PS_STATE;
	wire hit_wd = link.addr == PPDR_OFF_WATCHDOG;
	wire hit_dm = link.addr == PPDR_OFF_DISP_MODE;
	wire data_acc = link.req & hit_data;
	wire rd_crt = tsel_q == PPDR_TS_CRT;
	wire rd_none = tsel_q == PPDR_TS_RSVD;
	wire wr_lcd = (tsel_q == PPDR_TS_BOTH) | (tsel_q == PPDR_TS_LCD);
	wire wr_crt = (tsel_q == PPDR_TS_BOTH) | (tsel_q == PPDR_TS_CRT);
	// commit strobe on blue write only
	wire commit = data_acc & link.we & (phase_q == PPDR_PH_BLUE);

	// ***********************************
	// read data
	// ***********************************
	// component in the upper nibble, low nibble zero
	wire [3:0] tab_rd = rd_none ? 4'h0 : (rd_crt ? crt_tab[phase_q][ptr_q] : lcd_tab[phase_q][ptr_q]);
	// status bits straight from the power state
	wire [7:0] st_byte = {6'h00, panel_powered_down, memctl_powered_down};
	wire [7:0] rd_mux = hit_tsel ? {6'h00, tsel_q} :
		hit_ptr ? ptr_q :
		hit_data ? {tab_rd, 4'h0} :
		hit_cfg ? {3'h0, ps_rsvd_q, 3'h0, ps_en_q} :
		hit_st ? st_byte :
		hit_wd ? {2'h0, wd_n_q} :
		hit_dm ? {1'b0, rot_q, 3'h0, dsel_q} : 8'h00;
	assign link.ack = ack_q;
	assign link.rdata = rdata_q;

	// answer one cycle after each request
	always_ff @(posedge clock) begin
		ack_q <= ~rst & link.req;
		rdata_q <= rst ? PPDR_RESET_BYTE : (link.req ? rd_mux : rdata_q);
	end

	// ***********************************
	// configuration registers
	// ***********************************
	// plain stored fields
	always_ff @(posedge clock) begin
		if (rst) begin
			tsel_q <= PPDR_TS_BOTH;
			ps_en_q <= 1'b0;
			ps_rsvd_q <= 1'b0;
			wd_n_q <= '0;
			rot_q <= 1'b0;
			dsel_q <= 3'h0;
		end else if (wr) begin
			if (hit_tsel) tsel_q <= ppdr_tsel_t'(link.wdata[1:0]);
			if (hit_cfg) begin
				ps_en_q <= link.wdata[PPDR_PS_ENABLE_BIT];
				ps_rsvd_q <= link.wdata[PPDR_PS_RSVD_BIT];
			end
			if (hit_wd) wd_n_q <= link.wdata[PPDR_WD_W-1:0];
			if (hit_dm) begin
				rot_q <= link.wdata[PPDR_DM_ROT_BIT];
				dsel_q <= link.wdata[2:0];
			end
		end
	end

	// edge of select bit 0 starts the lcd sequence
	always_ff @(posedge clock) begin
		lcd_power_on_start <= ~rst & wr & hit_dm & link.wdata[0] & ~dsel_q[0];
		lcd_power_off_start <= ~rst & wr & hit_dm & ~link.wdata[0] & dsel_q[0];
	end

	assign power_save_enable = ps_en_q;
	assign image_rotation_90 = rot_q;
	assign lcd_enable = dsel_q[0];
	assign crt_enable = dsel_q[2:1] == 2'b01;
	assign tv_enable = dsel_q[2];
	assign flicker_enable = dsel_q[2:1] == 2'b11;
	assign simultaneous_display = dsel_q[0] & (dsel_q[2:1] != 2'b00);

	// ***********************************
	// palette pointer and staging
	// ***********************************
	// pointer load and auto advance
	always_ff @(posedge clock) begin
		if (rst) begin
			ptr_q <= 8'h00;
			phase_q <= PPDR_PH_RED;
		end else if (wr & hit_ptr) begin
			ptr_q <= link.wdata;
			phase_q <= PPDR_PH_RED;
		end else if (data_acc) begin
			case (phase_q)
				PPDR_PH_RED: phase_q <= PPDR_PH_GREEN;
				PPDR_PH_GREEN: phase_q <= PPDR_PH_BLUE;
				default: begin
					phase_q <= PPDR_PH_RED;
					ptr_q <= ptr_q + 8'h01;
				end
			endcase
		end
	end

	// hold red and green until blue arrives
	always_ff @(posedge clock) begin
		if (rst) begin
			stage_red_q <= '0;
			stage_green_q <= '0;
		end else if (data_acc & link.we) begin
			if (phase_q == PPDR_PH_RED) stage_red_q <= link.wdata[7:PPDR_DATA_LSB];
			if (phase_q == PPDR_PH_GREEN) stage_green_q <= link.wdata[7:PPDR_DATA_LSB];
		end
	end

	// selected tables written on blue, both when select is 0, no reset on memory
	always_ff @(posedge clock) begin
		if (commit & wr_lcd) begin
			lcd_tab[0][ptr_q] <= stage_red_q;
			lcd_tab[1][ptr_q] <= stage_green_q;
			lcd_tab[2][ptr_q] <= link.wdata[7:PPDR_DATA_LSB];
		end
		if (commit & wr_crt) begin
			crt_tab[0][ptr_q] <= stage_red_q;
			crt_tab[1][ptr_q] <= stage_green_q;
			crt_tab[2][ptr_q] <= link.wdata[7:PPDR_DATA_LSB];
		end
	end

	// pixel lookups; registered so pipelines see a clean edge
	always_ff @(posedge clock) begin
		lcd_rgb <= rst ? '0 : {lcd_tab[0][lcd_index], lcd_tab[1][lcd_index], lcd_tab[2][lcd_index]};
		crt_rgb <= rst ? '0 : {crt_tab[0][crt_index], crt_tab[1][crt_index], crt_tab[2][crt_index]};
	end

	// ***********************************
	// flicker filter
	// ***********************************
	// per-component mean of the two lines
	logic [3*COMP_W-1:0] avg;
	always_comb begin
		avg = '0;
		for (int c = 0; c < 3; c++) begin
			avg[c*COMP_W +: COMP_W] = COMP_W'(({1'b0, tv_line_cur[c*COMP_W +: COMP_W]}
				+ {1'b0, tv_line_prev[c*COMP_W +: COMP_W]}) >> 1);
		end
	end

	always_ff @(posedge clock) begin
		tv_pix <= rst ? '0 : (flicker_enable ? avg : tv_line_cur);
	end

	// ***********************************
	// memory access watchdog
	// ***********************************
	// strap is sampled while reset is held, so it is stable at release
	always_ff @(posedge clock) begin
		if (rst) strap_q <= bus_clock_divide_strap;
	end

	// bus part of the bound, doubled by the strap
	wire [PPDR_WD_CNT_W-1:0] wd_base = PPDR_WD_CNT_W'(PPDR_WD_MULT * wd_n_q + PPDR_WD_ADD);
	wire [PPDR_WD_CNT_W-1:0] wd_limit = strap_q ? (wd_base << 1) : wd_base;

	// only cpu memory cycles with non-zero n are timed
	always_ff @(posedge clock) begin
		if (rst | ~cpu_mem_cycle) begin
			wd_q <= PPDR_WD_IDLE;
			wd_cnt_q <= '0;
			wd_mclk_q <= 4'h0;
		end else begin
			case (wd_q)
				PPDR_WD_IDLE: begin
					if (wd_n_q != '0) wd_q <= PPDR_WD_BUS;
					wd_cnt_q <= PPDR_WD_CNT_W'(1);
				end
				PPDR_WD_BUS: begin
					wd_cnt_q <= wd_cnt_q + PPDR_WD_CNT_W'(1);
					if (wd_cnt_q >= wd_limit) wd_q <= PPDR_WD_MCLK;
				end
				PPDR_WD_MCLK: begin
					if (mclk_tick) wd_mclk_q <= wd_mclk_q + 4'h1;
					if (mclk_tick & (wd_mclk_q == PPDR_WD_MCLKS - 4'h1)) wd_q <= PPDR_WD_EXPIRE;
				end
				default: wd_q <= PPDR_WD_EXPIRE;
			endcase
		end
	end

	// forces the cycle to finish once the bound is used up
	assign mem_cycle_terminate = wd_q == PPDR_WD_EXPIRE;

endmodule // ppdr_device
`default_nettype wire

// [ppdr_host.sv]
// host controller end: avalon-mm slave for software, drives the register link
// assumes software polls busy before issuing the next request
`timescale 1ns/10ps
`default_nettype none
module ppdr_host
	import ppdr_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// clock and power conditions
	input wire logic lcd_pclk_running,
	input wire logic crt_pclk_running,
	input wire logic power_save_active,
	// system outputs
	output logic lcd_clock_stop_ok,
	output logic mem_clock_stop_ok,
	output logic tv_flicker_cfg,
	// register link
	ppdr_if.host link
);

	// ***********************************
	// software registers
	// ***********************************
	logic [8:0] addr_q;
	logic [7:0] wdata_q, rdata_q;
	logic busy_q, refused_q, we_q, req_q, ack_av_q;
	logic [1:0] tsel_q;
	logic [31:0] avrd_q;

	wire acc = avs_read | avs_write;
	wire go = avs_write & ~ack_av_q & (avs_address == PPDR_AV_CTRL) & |avs_writedata[1:0];
	wire go_we = avs_writedata[0];
	wire pal = (addr_q == PPDR_OFF_TABLE_SEL) | (addr_q == PPDR_OFF_INDEX_PTR) | (addr_q == PPDR_OFF_DATA_PORT);
	// palette needs its pixel clock and no power save
	wire clk_ok = (tsel_q == PPDR_TS_LCD) ? lcd_pclk_running :
		(tsel_q == PPDR_TS_CRT) ? crt_pclk_running : (lcd_pclk_running & crt_pclk_running);
	wire deny = pal & (power_save_active | ~clk_ok);
	wire launch = go & ~busy_q & ~deny;
	// reserved config bit forced to zero
	wire [7:0] out_data = (addr_q == PPDR_OFF_PS_CONFIG) ? (wdata_q & ~(8'h01 << PPDR_PS_RSVD_BIT)) : wdata_q;
	wire [31:0] rd_mux = (avs_address == PPDR_AV_ADDR) ? {23'h0, addr_q} :
		(avs_address == PPDR_AV_WDATA) ? {24'h0, wdata_q} :
		(avs_address == PPDR_AV_STATUS) ? {16'h0, rdata_q, 4'h0, mem_clock_stop_ok, lcd_clock_stop_ok, refused_q, busy_q} :
		32'h0;

	// one wait cycle on every access
	assign avs_waitrequest = acc & ~ack_av_q;
	assign avs_readdata = avrd_q;
	assign link.req = req_q;
	assign link.we = we_q;
	assign link.addr = addr_q;
	assign link.wdata = out_data;

	// avalon answer register
	always_ff @(posedge clock) begin
		ack_av_q <= ~rst & acc & ~ack_av_q;
		avrd_q <= rst ? 32'h0 : (avs_read ? rd_mux : avrd_q);
	end

	// software writes address and data while idle
	always_ff @(posedge clock) begin
		if (rst) begin
			addr_q <= 9'h000;
			wdata_q <= 8'h00;
		end else if (avs_write & ~ack_av_q & ~busy_q) begin
			if (avs_address == PPDR_AV_ADDR) addr_q <= avs_writedata[8:0];
			if (avs_address == PPDR_AV_WDATA) wdata_q <= avs_writedata[7:0];
		end
	end

	// ***********************************
	// link sequencing
	// ***********************************
	always_ff @(posedge clock) begin
		if (rst) begin
			busy_q <= 1'b0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			refused_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			req_q <= launch;
			if (launch) we_q <= go_we;
			if (go) refused_q <= ~launch;
			if (launch) busy_q <= 1'b1;
			else if (link.ack) busy_q <= 1'b0;
			if (link.ack & ~we_q) rdata_q <= link.rdata;
		end
	end

	// ***********************************
	// shadows of device state
	// ***********************************
	// clock-stop permission and tv config follow the device
	always_ff @(posedge clock) begin
		if (rst) begin
			tsel_q <= 2'b00;
			lcd_clock_stop_ok <= 1'b0;
			mem_clock_stop_ok <= 1'b0;
			tv_flicker_cfg <= 1'b0;
		end else if (link.ack) begin
			if (we_q & (addr_q == PPDR_OFF_TABLE_SEL)) tsel_q <= out_data[1:0];
			if (~we_q & (addr_q == PPDR_OFF_PS_STATE)) begin
				lcd_clock_stop_ok <= link.rdata[PPDR_ST_LCD_BIT];
				mem_clock_stop_ok <= link.rdata[PPDR_ST_MEM_BIT];
			end
			if (we_q & (addr_q == PPDR_OFF_PS_CONFIG)) begin
				lcd_clock_stop_ok <= 1'b0;
				mem_clock_stop_ok <= 1'b0;
			end
			if (we_q & (addr_q == PPDR_OFF_DISP_MODE)) tv_flicker_cfg <= out_data[2:1] == 2'b11;
		end
	end

endmodule // ppdr_host
`default_nettype wire

// [ppdr_props.sv]
// link checker: timing and field relations on the register link
// assumes the test top wires it beside the link between host and bank
`timescale 1ns/10ps
`default_nettype none
module ppdr_props
	import ppdr_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register link
	input wire logic req,
	input wire logic we,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ********************
	// link timing
	// ********************
	property p_ack_follows;
		req |=> ack;
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("no ack one cycle after req");
	property p_ack_cause;
		ack |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
	property p_one_out;
		req |=> !req ##1 !ack;
	endproperty
	a_one_out: assert property (p_one_out) else $error("req spacing broken");
	// read data only moves with an answer
	property p_rdata_hold;
		!ack |-> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without ack");

	// ********************
	// field relations
	// ********************
	property p_low_nibble;
		ack && !$past(we) && $past(addr) == PPDR_OFF_DATA_PORT |-> rdata[3:0] == 4'h0;
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("data port low bits set");
	property p_rsvd_zero;
		req && we && addr == PPDR_OFF_PS_CONFIG |-> !wdata[PPDR_PS_RSVD_BIT];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit written as 1");
	property p_wd_width;
		ack && !$past(we) && $past(addr) == PPDR_OFF_WATCHDOG |-> rdata[7:6] == 2'h0;
	endproperty
	a_wd_width: assert property (p_wd_width) else $error("watchdog upper bits set");
	property p_sel_width;
		ack && !$past(we) && $past(addr) == PPDR_OFF_TABLE_SEL |-> rdata[7:2] == 6'h00;
	endproperty
	a_sel_width: assert property (p_sel_width) else $error("table select upper bits set");

	// main scenarios reached
	c_data_rd: cover property (ack && !$past(we) && $past(addr) == PPDR_OFF_DATA_PORT);
	c_ps_wr: cover property (req && we && addr == PPDR_OFF_PS_CONFIG);
	c_wd_wr: cover property (req && we && addr == PPDR_OFF_WATCHDOG);
endmodule // ppdr_props
`default_nettype wire

// [ppdr_test.sv]
// self-checking bench: software side over avalon, bank side pins driven directly
// assumes both ends share one 10 MHz clock; memories start unknown
`timescale 1ns/10ps
`default_nettype none
module ppdr_test
	import ppdr_pkg::*;
;
	logic clock = 0;
	logic rst = 1;
	logic [2:0] av_a = 0;
	logic av_r = 0;
	logic av_w = 0;
	logic [31:0] av_wd = 0;
	logic [31:0] av_rd;
	logic av_wait;
	logic pnl = 0, mem = 0, cyc = 0, tick = 1, strap = 0, lrun = 1, crun = 1, psa = 0;
	logic [7:0] li = 0, ci = 0;
	logic [11:0] tc = 0, tp = 0, lrgb, crgb, tv;
	logic ps_en, rot, le, ce, te, fe, sd, pon, poff, term, lok, mok, tvf;
	logic [11:0] lcd_m [256];
	logic [11:0] crt_m [256];
	logic [31:0] s;
	logic [7:0] v, e;
	logic [3:0] c [6];
	int num_errors = 0, n_compared = 0, pon_n = 0, poff_n = 0, x_on = 0, x_off = 0, n;
	logic [8:0] offs [8] = '{PPDR_OFF_TABLE_SEL, PPDR_OFF_INDEX_PTR, PPDR_OFF_PS_CONFIG, PPDR_OFF_PS_STATE,
		PPDR_OFF_WATCHDOG, PPDR_OFF_DISP_MODE, 9'h1E6, 9'h1F8};

	ppdr_if lk();
	ppdr_host i_ppdr_host (.clock(clock), .rst(rst), .avs_address(av_a), .avs_read(av_r), .avs_write(av_w),
		.avs_writedata(av_wd), .avs_readdata(av_rd), .avs_waitrequest(av_wait), .lcd_pclk_running(lrun),
		.crt_pclk_running(crun), .power_save_active(psa), .lcd_clock_stop_ok(lok), .mem_clock_stop_ok(mok),
		.tv_flicker_cfg(tvf), .link(lk));
	ppdr_device i_ppdr_device (.clock(clock), .rst(rst), .link(lk), .panel_powered_down(pnl),
		.memctl_powered_down(mem), .cpu_mem_cycle(cyc), .mclk_tick(tick), .bus_clock_divide_strap(strap),
		.lcd_index(li), .crt_index(ci), .lcd_rgb(lrgb), .crt_rgb(crgb), .tv_line_cur(tc), .tv_line_prev(tp),
		.tv_pix(tv), .power_save_enable(ps_en), .image_rotation_90(rot), .lcd_enable(le), .crt_enable(ce),
		.tv_enable(te), .flicker_enable(fe), .simultaneous_display(sd), .lcd_power_on_start(pon),
		.lcd_power_off_start(poff), .mem_cycle_terminate(term));
	ppdr_props i_ppdr_props (.clock(clock), .rst(rst), .req(lk.req), .we(lk.we), .addr(lk.addr),
		.wdata(lk.wdata), .rdata(lk.rdata), .ack(lk.ack));

	// ********************
	// clock, pulse counters, helpers
	// ********************
	always #50 clock = ~clock;
	// counting pulses avoids racing the one-cycle strobes
	always @(posedge clock) begin
		pon_n += (pon === 1'b1);
		poff_n += (poff === 1'b1);
	end
	function automatic logic [11:0] avg(input logic [11:0] a, input logic [11:0] b);
		for (int i = 0; i < 12; i += 4) avg[i+:4] = 4'((5'(a[i+:4]) + 5'(b[i+:4])) >> 1);
	endfunction
	function automatic int wd_bound(input int k, input logic st);
		return (8 * k + 7) * (st ? 2 : 1) + 13;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %0t got %0h want %0h", $time, g, x);
		end
	endtask
	// one avalon access; waitrequest and readdata are taken at the rising edge that ends it
	task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		av_a <= a;
		av_w <= w;
		av_r <= !w;
		av_wd <= d;
		// pre-edge values are seen here, so the request stands at the sampling edge
		do begin
			@(posedge clock);
			q = av_rd;
		end while (av_wait !== 1'b0);
		av_w <= 0;
		av_r <= 0;
	endtask
	// one link transfer; an extra status read guards against a lagging readdata register
	task automatic op(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [31:0] q);
		av(1, PPDR_AV_ADDR, {23'h0, a}, q);
		av(1, PPDR_AV_WDATA, {24'h0, d}, q);
		av(1, PPDR_AV_CTRL, w ? 32'h1 : 32'h2, q);
		repeat (4) @(posedge clock);
		do av(0, PPDR_AV_STATUS, 32'h0, q); while (q[0] !== 1'b0);
		av(0, PPDR_AV_STATUS, 32'h0, q);
	endtask
	task automatic measure(output int k);
		cyc <= 1;
		k = 0;
		while (k < 1100) begin
			@(negedge clock);
			if (term === 1'b1) break;
			k++;
		end
		@(posedge clock);
		cyc <= 0;
		repeat (3) @(posedge clock);
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ********************
	// tests
	// ********************
	initial begin
		void'($urandom(10));
		repeat (2) @(posedge clock);
		rst <= 0;
		foreach (offs[i]) begin
			op(0, offs[i], 8'h00, s);
			chk(s[15:8], PPDR_RESET_BYTE);
		end
		$display("reset values done");
		op(1, PPDR_OFF_PS_CONFIG, 8'h11, s);
		chk(ps_en, 1);
		op(0, PPDR_OFF_PS_CONFIG, 8'h00, s);
		chk(s[15:8], 8'h01);
		for (int i = 0; i < 4; i++) begin
			pnl <= i[1];
			mem <= i[0];
			op(0, PPDR_OFF_PS_STATE, 8'h00, s);
			chk(s[15:8], {6'h0, i[1:0]});
			chk({lok, mok}, i[1:0]);
		end
		op(1, PPDR_OFF_PS_CONFIG, 8'h00, s);
		chk({ps_en, lok, mok}, 0);
		$display("power save done");
		// select starts at zero after reset, so the first edge is counted against that
		v = 8'h00;
		for (int m = 0; m < 16; m++) begin
			x_on += (!v[0] && m[0]);
			x_off += (v[0] && !m[0]);
			v = {1'b0, m[3], 3'h0, m[2:0]};
			tc <= 12'($urandom);
			tp <= 12'($urandom);
			op(1, PPDR_OFF_DISP_MODE, v, s);
			chk({rot, le, ce, te, fe, sd}, {v[6], v[0], v[2:1] == 2'b01, v[2], v[2:1] == 2'b11,
				v[0] && v[2:1] != 0});
			chk(tv, (v[2:1] == 2'b11) ? avg(tc, tp) : tc);
			chk(tvf, v[2:1] == 2'b11);
		end
		chk(pon_n, x_on);
		chk(poff_n, x_off);
		chk(rot, 1);
		$display("display mode done");
		for (int t = 0; t < 3; t++) begin
			op(1, PPDR_OFF_TABLE_SEL, 8'(t), s);
			op(1, PPDR_OFF_INDEX_PTR, 8'hFF, s);
			for (int k = 0; k < 6; k++) begin
				c[k] = 4'($urandom);
				e = 8'hFF + 8'(k / 3);
				op(1, PPDR_OFF_DATA_PORT, {c[k], 4'($urandom)}, s);
				li <= e;
				ci <= e;
				repeat (2) @(posedge clock);
				if (k % 3 == 2) begin
					if (t != 2) lcd_m[e] = {c[k-2], c[k-1], c[k]};
					if (t != 1) crt_m[e] = {c[k-2], c[k-1], c[k]};
				end
				if (t > 0 || k % 3 == 2) chk({lrgb, crgb}, {lcd_m[e], crt_m[e]});
			end
			op(1, PPDR_OFF_INDEX_PTR, 8'hFF, s);
			for (int k = 0; k < 6; k++) begin
				e = 8'hFF + 8'(k / 3);
				op(0, PPDR_OFF_DATA_PORT, 8'h00, s);
				chk(s[15:8], {4'((t == 2 ? crt_m[e] : lcd_m[e]) >> (4 * (2 - k % 3))), 4'h0});
			end
		end
		// reserved table select reads nothing back
		op(1, PPDR_OFF_TABLE_SEL, 8'h03, s);
		op(0, PPDR_OFF_DATA_PORT, 8'h00, s);
		chk(s[15:8], 8'h00);
		$display("palette done");
		psa <= 1;
		op(1, PPDR_OFF_INDEX_PTR, 8'h05, s);
		chk(s[1], 1);
		psa <= 0;
		op(1, PPDR_OFF_TABLE_SEL, 8'h01, s);
		lrun <= 0;
		op(0, PPDR_OFF_DATA_PORT, 8'h00, s);
		chk(s[1], 1);
		lrun <= 1;
		$display("refusal done");
		measure(n);
		chk(n, 1100);
		op(1, PPDR_OFF_WATCHDOG, 8'h01, s);
		measure(n);
		chk(n inside {[wd_bound(1, 0) - 2 : wd_bound(1, 0) + 2]}, 1);
		repeat (50) @(posedge clock);
		chk(term, 0);
		strap <= 1;
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		op(1, PPDR_OFF_WATCHDOG, 8'h3F, s);
		measure(n);
		chk(n inside {[wd_bound(63, 1) - 2 : wd_bound(63, 1) + 2]}, 1);
		$display("watchdog done");
		stop_test();
	end

	// hang guard, well beyond the planned run length
	initial begin
		#3000000;
		num_errors++;
		stop_test();
	end
endmodule // ppdr_test
`default_nettype wire
